// [common/icf_consts.svh]
// Constants of the interrupt control and flag status block: register
// offsets, field positions, implemented-bit masks and reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ICF_CONSTS_SVH
`define ICF_CONSTS_SVH

// ==========================================================================
// Register byte offsets on the APB bus.
`define ICF_ADDR_W 8
`define ICF_OFS_CTRL 8'h00
`define ICF_OFS_FLAG0 8'h04
`define ICF_OFS_FLAG1 8'h08
`define ICF_OFS_FLAG2 8'h0C
`define ICF_OFS_EVT_STAT 8'h10
`define ICF_OFS_EVT_MASK 8'h14

// ==========================================================================
// Widths.
`define ICF_REG_W 16
`define ICF_EXT_NUM 5
`define ICF_EVT_W 4

// ==========================================================================
// Control register fields and masks.
`define ICF_CTRL_ALT_BIT 15
`define ICF_CTRL_TDIS_BIT 14
`define ICF_CTRL_EDGE_LSB 0
`define ICF_CTRL_WR_MASK 16'h801F

// ==========================================================================
// Implemented flag positions per flag register.
`define ICF_FLAG0_IMPL 16'h3FEF
`define ICF_FLAG1_IMPL 16'hFEDF
`define ICF_FLAG2_IMPL 16'h3FE3
`define ICF_EXT0_POS 0
`define ICF_EXT1_POS 4
`define ICF_EXT2_POS 13

// ==========================================================================
// Event status bits: one per flag register, then timed-disable start.
`define ICF_EVT_TDIS_BIT 3
`define ICF_RESET_VAL 16'h0000

`endif

// [common/icf_pkg.sv]
// Types shared by the interrupt control and flag status design files.
// Assumes icf_consts.svh is on the include path.
`include "icf_consts.svh"

package icf_pkg;

  // ========================================================================
  // Bus handshake states, one-hot.
  typedef enum logic [2:0]
  {
    ICF_IDLE = 3'h1,
    ICF_WAIT = 3'h2,
    ICF_DONE = 3'h4
  } icf_bus_state_t;

  // ========================================================================
  // Whole state of the top module.
  typedef struct packed
  {
    icf_bus_state_t bus;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic alt_sel;
    logic tdis;
    logic [`ICF_EXT_NUM-1:0] edge_sel;
    logic [`ICF_EVT_W-1:0] evt_stat;
    logic [`ICF_EVT_W-1:0] evt_mask;
    logic irq;
  } icf_top_state_t;

  // Whole state of the edge detector.
  typedef struct packed
  {
    logic [`ICF_EXT_NUM-1:0] sync1;
    logic [`ICF_EXT_NUM-1:0] sync2;
    logic [`ICF_EXT_NUM-1:0] prev;
    logic [1:0] fill;
    logic [`ICF_EXT_NUM-1:0] evt;
  } icf_edge_state_t;

endpackage : icf_pkg

// [verilog/icf_edge_det.sv]
// Synchroniser and selectable edge detector for the external interrupt pins.
// Assumes pins may change at any time; one event pulse per detected edge.
`timescale 1ns/10ps
`default_nettype none
`include "icf_consts.svh"

module icf_edge_det
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`ICF_EXT_NUM-1:0] pin,
  input wire logic [`ICF_EXT_NUM-1:0] edge_sel,
  output logic [`ICF_EXT_NUM-1:0] event_q
);

  icf_pkg::icf_edge_state_t st_q;
  icf_pkg::icf_edge_state_t st_d;
  logic [`ICF_EXT_NUM-1:0] det;

  // ========================================================================
  // Per-pin detection: high selects the falling edge, low the rising one.
  genvar gi;
  generate
    for (gi = 0; gi < `ICF_EXT_NUM; gi = gi + 1)
    begin : g_det
      assign det[gi] = edge_sel[gi] ? (st_q.prev[gi] & ~st_q.sync2[gi])
                                    : (~st_q.prev[gi] & st_q.sync2[gi]);
    end
  endgenerate

  // ========================================================================
  // Detection waits until sync1, sync2 and prev all hold real pin samples,
  // so a pin that is already high at reset release does not fake an edge.
  // The fill field counts 0, 1, 2, 3 and then stays at 3.
  always_comb
  begin
    st_d = st_q;
    st_d.sync1 = pin;
    st_d.sync2 = st_q.sync1;
    st_d.prev = st_q.sync2;
    st_d.fill = {|st_q.fill, st_q.fill[1] | ~st_q.fill[0]};
    st_d.evt = (&st_q.fill) ? det : '0;
  end

  // Single register stage for the whole state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign event_q = st_q.evt;

endmodule : icf_edge_det
`default_nettype wire

// [verilog/icf_flag_reg.sv]
// One sixteen-bit interrupt flag status register with hardware set inputs.
// Assumes the write strobe lasts one cycle and set inputs are pulses or levels.
`timescale 1ns/10ps
`default_nettype none
`include "icf_consts.svh"

module icf_flag_reg
#(
  parameter logic [`ICF_REG_W-1:0] IMPL = `ICF_FLAG0_IMPL
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [`ICF_REG_W-1:0] wdata,
  input wire logic [`ICF_REG_W-1:0] hw_set,
  output logic [`ICF_REG_W-1:0] flags_q
);

  logic [`ICF_REG_W-1:0] flags_d;

  // ========================================================================
  // Software write replaces the stored value, then any hardware set is
  // ORed on top so a request arriving during the clear is never lost.
  always_comb
  begin
    flags_d = flags_q;
    if (wr_en)
    begin
      flags_d = wdata & IMPL;
    end
    flags_d = flags_d | (hw_set & IMPL);
  end

  // Flags clear at reset; unimplemented positions never hold a one.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_q <= `ICF_RESET_VAL;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

endmodule : icf_flag_reg
`default_nettype wire

// [verilog/icf_top.sv]
// Top of the interrupt control and flag status block: APB register slave,
// vector table select, timed-disable status, edge selects and three flag
// registers, plus a masked event interrupt.
// Assumes one clock pclk at 100 MHz and an APB master that holds requests.
`timescale 1ns/10ps
`default_nettype none
`include "icf_consts.svh"

module icf_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ICF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timed_disable_active,
  input wire logic [`ICF_EXT_NUM-1:0] ext_irq_pin,
  input wire logic [`ICF_REG_W-1:0] periph_set_0,
  input wire logic [`ICF_REG_W-1:0] periph_set_1,
  input wire logic [`ICF_REG_W-1:0] periph_set_2,
  output logic alt_vector_table_sel,
  output logic [`ICF_EXT_NUM-1:0] ext_irq_event,
  output logic [`ICF_REG_W-1:0] irq_flag_status_0,
  output logic [`ICF_REG_W-1:0] irq_flag_status_1,
  output logic [`ICF_REG_W-1:0] irq_flag_status_2,
  output logic irq
);

  icf_pkg::icf_top_state_t st_q;
  icf_pkg::icf_top_state_t st_d;
  logic [`ICF_EXT_NUM-1:0] ext_evt;
  logic [`ICF_REG_W-1:0] set0;
  logic [`ICF_REG_W-1:0] set1;
  logic [`ICF_REG_W-1:0] set2;
  logic [`ICF_REG_W-1:0] ctrl_view;
  logic wr_commit;
  logic wr_flag0;
  logic wr_flag1;
  logic wr_flag2;
  logic [`ICF_EVT_W-1:0] evt_set;

  // ==========================================================================
  // External pins: synchroniser and edge detector.
  icf_edge_det u_edge
  (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_irq_pin),
    .edge_sel(st_q.edge_sel),
    .event_q(ext_evt)
  );

  // ==========================================================================
  // Hardware set vectors; external events 0 to 2 land in vector-order positions, events 3 and 4 set no flag.
  always_comb
  begin
    set0 = periph_set_0;
    set1 = periph_set_1;
    set2 = periph_set_2;
    set0[`ICF_EXT0_POS] = periph_set_0[`ICF_EXT0_POS] | ext_evt[0];
    set1[`ICF_EXT1_POS] = periph_set_1[`ICF_EXT1_POS] | ext_evt[1];
    set1[`ICF_EXT2_POS] = periph_set_1[`ICF_EXT2_POS] | ext_evt[2];
  end

  // A write commits only at the edge where pready is sampled high.
  assign wr_commit = (st_q.bus == icf_pkg::ICF_DONE) & psel & penable & pwrite;
  assign wr_flag0 = wr_commit & (paddr == `ICF_OFS_FLAG0);
  assign wr_flag1 = wr_commit & (paddr == `ICF_OFS_FLAG1);
  assign wr_flag2 = wr_commit & (paddr == `ICF_OFS_FLAG2);

  // ==========================================================================
  // The three flag registers, each masked to its implemented positions.
  icf_flag_reg #(.IMPL(`ICF_FLAG0_IMPL)) u_flag0
  (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_flag0),
    .wdata(pwdata[`ICF_REG_W-1:0]),
    .hw_set(set0),
    .flags_q(irq_flag_status_0)
  );

  icf_flag_reg #(.IMPL(`ICF_FLAG1_IMPL)) u_flag1
  (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_flag1),
    .wdata(pwdata[`ICF_REG_W-1:0]),
    .hw_set(set1),
    .flags_q(irq_flag_status_1)
  );

  icf_flag_reg #(.IMPL(`ICF_FLAG2_IMPL)) u_flag2
  (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_flag2),
    .wdata(pwdata[`ICF_REG_W-1:0]),
    .hw_set(set2),
    .flags_q(irq_flag_status_2)
  );

  // ==========================================================================
  // Control register as software sees it; absent bits are held at zero.
  always_comb
  begin
    ctrl_view = `ICF_RESET_VAL;
    ctrl_view[`ICF_CTRL_ALT_BIT] = st_q.alt_sel;
    ctrl_view[`ICF_CTRL_TDIS_BIT] = st_q.tdis;
    ctrl_view[`ICF_EXT_NUM-1:0] = st_q.edge_sel;
  end

  // Block events: any new set into a flag register, and timed disable start.
  assign evt_set = {timed_disable_active & ~st_q.tdis,
                    |(set2 & `ICF_FLAG2_IMPL),
                    |(set1 & `ICF_FLAG1_IMPL),
                    |(set0 & `ICF_FLAG0_IMPL)};

  // ==========================================================================
  // Bus handshake, register writes, read capture and event status.
  // Read data is captured at the same edge that raises pready so it stands the whole
  // ready cycle; the price is one wait state on every transfer.
  always_comb
  begin
    st_d = st_q;
    st_d.pready = 1'b0;
    st_d.tdis = timed_disable_active;
    case (st_q.bus)
      icf_pkg::ICF_IDLE:
      begin
        if (psel && !penable)
        begin
          st_d.bus = icf_pkg::ICF_WAIT;
        end
      end
      icf_pkg::ICF_WAIT:
      begin
        if (psel && penable)
        begin
          st_d.bus = icf_pkg::ICF_DONE;
          st_d.pready = 1'b1;
          st_d.pslverr = 1'b0;
          st_d.prdata = 32'h0000_0000;
          case (paddr)
            `ICF_OFS_CTRL: st_d.prdata[`ICF_REG_W-1:0] = ctrl_view;
            `ICF_OFS_FLAG0: st_d.prdata[`ICF_REG_W-1:0] = irq_flag_status_0;
            `ICF_OFS_FLAG1: st_d.prdata[`ICF_REG_W-1:0] = irq_flag_status_1;
            `ICF_OFS_FLAG2: st_d.prdata[`ICF_REG_W-1:0] = irq_flag_status_2;
            `ICF_OFS_EVT_STAT: st_d.prdata[`ICF_EVT_W-1:0] = st_q.evt_stat;
            `ICF_OFS_EVT_MASK: st_d.prdata[`ICF_EVT_W-1:0] = st_q.evt_mask;
            default: st_d.pslverr = 1'b1;
          endcase
          if (!pwrite)
          begin
            st_d.prdata = st_d.pslverr ? 32'h0000_0000 : st_d.prdata;
          end
        end
        else
        begin
          st_d.bus = icf_pkg::ICF_IDLE;
        end
      end
      icf_pkg::ICF_DONE:
      begin
        st_d.bus = icf_pkg::ICF_IDLE;
        st_d.pslverr = 1'b0;
        if (wr_commit && paddr == `ICF_OFS_CTRL)
        begin
          st_d.alt_sel = pwdata[`ICF_CTRL_ALT_BIT];
          st_d.edge_sel = pwdata[`ICF_EXT_NUM-1:0];
        end
        if (wr_commit && paddr == `ICF_OFS_EVT_STAT)
        begin
          st_d.evt_stat = st_q.evt_stat & ~pwdata[`ICF_EVT_W-1:0];
        end
        if (wr_commit && paddr == `ICF_OFS_EVT_MASK)
        begin
          st_d.evt_mask = pwdata[`ICF_EVT_W-1:0];
        end
      end
      default:
      begin
        st_d.bus = icf_pkg::ICF_IDLE;
      end
    endcase
    // Set after clear, so an event in the clearing cycle survives.
    st_d.evt_stat = st_d.evt_stat | evt_set;
    st_d.irq = |(st_d.evt_stat & st_d.evt_mask);
  end

  // One register stage for all top-level state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
      st_q.bus <= icf_pkg::ICF_IDLE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs, all from flip-flops.
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign alt_vector_table_sel = st_q.alt_sel;
  assign ext_irq_event = ext_evt;
  assign irq = st_q.irq;

  // ==========================================================================
  // Checks and coverage.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_alt_sel;
    wr_commit && paddr == `ICF_OFS_CTRL |=> alt_vector_table_sel == $past(pwdata[15]);
  endproperty
  a_alt_sel: assert property (p_alt_sel) else $error("Vector table select missed write.");

  property p_tdis_read;
    $rose(pready) && $past(paddr) == `ICF_OFS_CTRL && !$past(pwrite)
      |-> prdata[14] == $past(timed_disable_active, 2);
  endproperty
  a_tdis_read: assert property (p_tdis_read) else $error("Timed disable bit misread.");

  property p_ctrl_gaps;
    pready && !pslverr && paddr == `ICF_OFS_CTRL
      |-> prdata[31:16] == 16'h0000 && prdata[13:5] == 9'h000
          && prdata[15] == alt_vector_table_sel;
  endproperty
  a_ctrl_gaps: assert property (p_ctrl_gaps) else $error("Control gap bits not zero.");

  // Edge selects take the low write bits at the write edge.
  property p_edge_write;
    wr_commit && paddr == `ICF_OFS_CTRL |=> st_q.edge_sel == $past(pwdata[`ICF_EXT_NUM-1:0]);
  endproperty
  a_edge_write: assert property (p_edge_write) else $error("Edge select missed write.");

  // A refused read must not leak register contents.
  property p_err_read;
    pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
  endproperty
  a_err_read: assert property (p_err_read) else $error("Refused read returned data.");

  property p_flag_gaps;
    (irq_flag_status_0 & ~`ICF_FLAG0_IMPL) == 16'h0000 &&
    (irq_flag_status_1 & ~`ICF_FLAG1_IMPL) == 16'h0000 &&
    (irq_flag_status_2 & ~`ICF_FLAG2_IMPL) == 16'h0000;
  endproperty
  a_flag_gaps: assert property (p_flag_gaps) else $error("Flag gap bit set.");

  property p_sticky;
    irq_flag_status_1[3] && !wr_flag1 |=> irq_flag_status_1[3];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Flag dropped without write.");

  property p_ext0_pos;
    ext_evt[0] |=> irq_flag_status_0[0];
  endproperty
  a_ext0_pos: assert property (p_ext0_pos) else $error("External 0 flag not set.");

  // Pin seen high at k+1, event registered at k+3, flag set at k+4.
  property p_ext_edge;
    !st_q.edge_sel[2] && $rose(ext_irq_pin[2])
      ##1 (ext_irq_pin[2] && !st_q.edge_sel[2]) [*2] |-> ##2 irq_flag_status_1[13];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("External 2 edge not flagged.");

  property p_set_wins;
    wr_flag0 && set0[13] |=> irq_flag_status_0[13];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Set lost to write.");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held two cycles.");

  c_ctrl_read: cover property (pready && !pwrite && paddr == `ICF_OFS_CTRL);
  c_collide: cover property (wr_flag1 && set1[15]);
  c_irq_rise: cover property ($rose(irq));
  c_fall_edge: cover property (st_q.edge_sel[0] && ext_evt[0]);
  c_refused: cover property (pready && pslverr);

endmodule : icf_top
`default_nettype wire

// [verification/icf_src_model.sv]
// Model of the peripheral sources that raise flag set requests.
// Assumes the bench drives fire, hold, bank and bits just after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module icf_src_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic hold,
  input wire logic [1:0] bank,
  input wire logic [15:0] bits,
  output logic [15:0] set_0,
  output logic [15:0] set_1,
  output logic [15:0] set_2
);
  // ==========================================================================
  // Set requests
  // A request is a one-cycle pulse, or a level for as long as hold stays high.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      set_0 <= 16'h0000;
      set_1 <= 16'h0000;
      set_2 <= 16'h0000;
    end
    else
    begin
      set_0 <= (fire && bank == 2'h0) ? bits : (hold ? set_0 : 16'h0000);
      set_1 <= (fire && bank == 2'h1) ? bits : (hold ? set_1 : 16'h0000);
      set_2 <= (fire && bank == 2'h2) ? bits : (hold ? set_2 : 16'h0000);
    end
  end
endmodule : icf_src_model

`default_nettype wire

// [verification/icf_top_bench.sv]
// Self-checking bench of the interrupt control and flag status block.
// Assumes the design files and icf_src_model.sv are compiled before it.
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) \
  begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module icf_top_bench;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, tda, fire, hold, irq, pready, pslverr, alt_sel;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] pins, ext_irq_event;
  logic [1:0] bank;
  logic [15:0] bits, s0, s1, s2, f0, f1, f2;
  int failures = 0;
  int checks_done = 0;

  // Clock of 100 MHz.
  always #5 pclk = ~pclk;

  icf_src_model icf_src_model_i (.pclk(pclk), .presetn(presetn), .fire(fire), .hold(hold),
    .bank(bank), .bits(bits), .set_0(s0), .set_1(s1), .set_2(s2));

  icf_top icf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timed_disable_active(tda), .ext_irq_pin(pins), .periph_set_0(s0),
    .periph_set_1(s1), .periph_set_2(s2), .alt_vector_table_sel(alt_sel),
    .ext_irq_event(ext_irq_event), .irq_flag_status_0(f0), .irq_flag_status_1(f1),
    .irq_flag_status_2(f2), .irq(irq));

  // ==========================================================================
  // Tasks
  // Counts, verdict and end of the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // One APB transfer, pready sampled at rising edges. A held set request is
  // dropped only after the write edge, so it still meets the write there.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      failures++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    hold <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h00000000, rd, er);
    `CHK(nm, e, rd)
  endtask : rd_chk

  task automatic fire_set(input int b, input logic [15:0] v, input logic h);
    @(posedge pclk);
    fire <= 1'b1;
    bank <= 2'(b);
    bits <= v;
    hold <= h;
    @(posedge pclk);
    fire <= 1'b0;
  endtask : fire_set

  // Implemented flag positions of each flag register.
  function automatic logic [15:0] impl(input int b);
    return (b == 0) ? 16'h3FEF : (b == 1) ? 16'hFEDF : 16'h3FE3;
  endfunction : impl

  // ==========================================================================
  // Main sequence
  initial
  begin
    int i, p, n, b;
    logic [31:0] v, rd;
    logic er;
    {presetn, psel, penable, pwrite, tda, fire, hold} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pins = 5'h00;
    bank = 2'h0;
    bits = 16'h0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(1812));
    for (i = 0; i < 6; i++)
      rd_chk(8'(4 * i), 32'h00000000, "reset value");
    apb(1'b0, 8'h18, 32'h00000000, rd, er);
    `CHK("unmapped error", 1'b1, er)
    $display("test reset done");
    wr(8'h00, 32'hFFFFFFFF);
    rd_chk(8'h00, 32'h0000801F, "control mask");
    `CHK("alt table", 1'b1, alt_sel)
    wr(8'h00, 32'h00000000);
    @(posedge pclk);
    `CHK("std table", 1'b0, alt_sel)
    tda <= 1'b1;
    rd_chk(8'h00, 32'h00004000, "disable status");
    tda <= 1'b0;
    rd_chk(8'h00, 32'h00000000, "disable off");
    $display("test control done");
    // Full sets first, then random sets; each set is followed by software writes.
    for (i = 0; i < 15; i++)
    begin
      b = i % 3;
      v = (i < 3) ? 32'h0000FFFF : $urandom;
      fire_set(b, v[15:0], 1'b0);
      repeat (10) @(posedge pclk);
      rd_chk(8'(4 * b + 4), {16'h0000, impl(b) & v[15:0]}, "hw flag");
      v = $urandom;
      wr(8'(4 * b + 4), v);
      rd_chk(8'(4 * b + 4), {16'h0000, impl(b) & v[15:0]}, "sw flag");
      wr(8'(4 * b + 4), 32'h00000000);
    end
    fire_set(0, 16'h2000, 1'b1);
    wr(8'h04, 32'h00000000);
    rd_chk(8'h04, 32'h00002000, "set beats write");
    $display("test flags done");
    for (i = 0; i < 5; i++)
      for (p = 0; p < 2; p++)
      begin
        wr(8'h00, 32'(p << i));
        pins <= (p == 1) ? 5'h1F : 5'h00;
        repeat (8) @(posedge pclk);
        wr(8'h04, 32'h00000000);
        wr(8'h08, 32'h00000000);
        @(posedge pclk);
        pins[i] <= ~p[0];
        n = 0;
        while (ext_irq_event[i] !== 1'b1 && n < 12)
        begin
          @(negedge pclk);
          n++;
        end
        `CHK("edge event", 1'b1, ext_irq_event[i])
        @(negedge pclk);
        if (i < 3)
          `CHK("ext flag", 1'b1, (i == 0) ? f0[0] : (i == 1) ? f1[4] : f1[13])
        @(posedge pclk);
        pins[i] <= p[0];
        n = 0;
        repeat (10)
        begin
          @(negedge pclk);
          if (ext_irq_event[i] === 1'b1)
            n++;
        end
        `CHK("wrong edge", 0, n)
      end
    $display("test edges done");
    wr(8'h10, 32'h0000000F);
    wr(8'h14, 32'h00000001);
    fire_set(0, 16'h0001, 1'b0);
    repeat (3) @(posedge pclk);
    `CHK("irq raised", 1'b1, irq)
    rd_chk(8'h10, 32'h00000001, "event status");
    wr(8'h10, 32'h00000001);
    @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    wr(8'h14, 32'h00000000);
    fire_set(0, 16'h0001, 1'b0);
    repeat (3) @(posedge pclk);
    `CHK("irq masked", 1'b0, irq)
    rd_chk(8'h10, 32'h00000001, "masked status");
    $display("test interrupt done");
    wrap_up();
  end
endmodule : icf_top_bench

`default_nettype wire
